//--- design/asc_pkg.sv
// Constants and types shared by the converter sequence control block
`default_nettype none
package asc_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] ASC_CTRL_IDX = 3'h0;
    localparam logic [2:0] ASC_RES0_IDX = 3'h1;
    localparam logic [2:0] ASC_IRQ_STAT_IDX = 3'h5;
    localparam logic [2:0] ASC_IRQ_MASK_IDX = 3'h6;

    // Control word field positions
    localparam int ASC_ENABLE_BIT = 15;
    localparam int ASC_FLAG_BIT = 12;
    localparam int ASC_AFTER4_BIT = 11;
    localparam int ASC_IRQEN_BIT = 10;
    localparam int ASC_SRC_LSB = 8;
    localparam int ASC_DIV_LSB = 5;
    localparam int ASC_MODE_LSB = 3;
    localparam int ASC_CHAN_LSB = 0;

    // Writable control bits; reserved 14:13 and the flag are excluded
    localparam logic [15:0] ASC_CTRL_WMASK = 16'h8FFF;
    localparam logic [15:0] ASC_CTRL_RST = 16'h0000;
    localparam logic [2:0] ASC_IRQ_RST = 3'h0;

    // Status event bits
    localparam int ASC_EV_FLAG = 0;
    localparam int ASC_EV_RESULT = 1;
    localparam int ASC_EV_SEQDONE = 2;

    // Divider step and phase lengths in divided converter clocks
    localparam int ASC_DIV_STEP = 8;
    localparam logic [2:0] ASC_AZ_TICKS = 3'h2;
    localparam logic [2:0] ASC_SAMPLE_TICKS = 3'h2;
    localparam logic [2:0] ASC_CONV_TICKS = 3'h4;

    // Start sources
    typedef enum logic [1:0] {
        ASC_SRC_WRITE = 2'h0,
        ASC_SRC_EXT1 = 2'h1,
        ASC_SRC_GT2 = 2'h2,
        ASC_SRC_T0 = 2'h3
    } asc_src_t;

    // Sequencing modes
    typedef enum logic [1:0] {
        ASC_MODE_QUAD = 2'h0,
        ASC_MODE_SINGLE = 2'h1,
        ASC_MODE_SCAN = 2'h2,
        ASC_MODE_LOOP = 2'h3
    } asc_mode_t;

    // Conversion phases
    typedef enum logic [1:0] {
        ASC_IDLE,
        ASC_AZERO,
        ASC_SAMPLE,
        ASC_CONVERT
    } asc_state_t;
endpackage : asc_pkg
`default_nettype wire

//--- design/asc_sequence_control.sv
// Four-channel converter sequence control with control word and results
`default_nettype none

// Register map on the plain register port, index in reg_addr
//   0     control word: enable, flag, irq options, start, divider,
//         mode and first channel
//   1..4  result registers for slots zero to three, low eight bits
//   5     sticky event status, write one to clear
//   6     event mask, same layout as the status register
//   7     unmapped, reads zero and ignores writes
//
// Event status bits
//   bit 0 conversion flag was set
//   bit 1 a result register was written
//   bit 2 a stopping sequence has finished
//
// Conversion timing
//   The converter clock is a one-cycle enable pulse from a divider that
//   restarts with each start, so every phase gets whole periods and the
//   first tick lands a full period after the start edge. One conversion
//   is auto-zero, sample and convert, each a fixed number of ticks. The
//   result from the core is taken on the last convert tick.
//
// Start and abort
//   Any start, from a control write or from the selected trigger pulse,
//   drops whatever is running and begins a fresh auto-zero. Clearing the
//   enable bit stops the sequencer in the same cycle as the write. The
//   core then sees no phase level, which saves its power.
//
// Limitations
//   Trigger inputs are taken as one-cycle pulses already in this clock
//   domain; a level held high would restart the conversion every cycle
//   and so never finish. The caller must shape the pulse.
//   The flag counts completions since the last start only, so in the
//   continuous mode it is set once per start, not once per lap.
//   Reserved control bits read as zero whatever software writes there.
//
// Trade-offs
//   Read data are registered, so a read answers one cycle later and is
//   zero in every other cycle; this keeps the read path off the result
//   array timing at the cost of a cycle of latency.
//   The completion counter saturates instead of wrapping, so a long
//   continuous run can never raise a second flag by accident.


// How it works
// - Four inputs, each conversion yields eight bits
// - Auto-zero phase precedes every sampling phase
// - Converter clock divides by eight times code+1
// - Start source: write, irq one, timers
// - New start aborts and restarts a conversion
// - Mode picks quad, single, scan or loop
// - Quad mode fills results zero to three
// - Other modes write the converted channel's result
// - Scan starts at first channel, wraps upward
// - First channel field selects input zero-three
// - Enable low blocks everything but enable write
// - Flag read-only, cleared by control writes
// - After-fourth bit picks first or fourth completion
// - Irq enable bit suppresses or permits flag
// - Four readable result registers
module asc_sequence_control
    import asc_pkg::*;
#(
    parameter int RES_W = 8,
    parameter int NUM_CH = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Start triggers, one-cycle pulses
    input wire logic external_irq_one,
    input wire logic general_timer_two,
    input wire logic timer_zero,
    // Analog core side
    input wire logic [RES_W-1:0] core_result,
    output logic [1:0] core_channel,
    output logic core_autozero,
    output logic core_sample,
    output logic core_convert,
    output logic core_clk_en,
    // Interrupt
    output logic irq
);

    localparam int SLOT_W = $clog2(NUM_CH);

    // Divisor for a code: 8 * (code + 1), minus one for terminal count
    function automatic logic [5:0] div_last(input logic [2:0] code);
        div_last = 6'(ASC_DIV_STEP * (int'(code) + 1) - 1);
    endfunction : div_last

    // Channel after the given one, wrapping from three to zero
    function automatic logic [1:0] next_ch(input logic [1:0] ch);
        next_ch = ch + 2'h1;
    endfunction : next_ch

    logic [15:0] ctrl_ff;
    logic flag_ff;
    logic [RES_W-1:0] result_ff [NUM_CH];
    logic [2:0] irq_stat_ff;
    logic [2:0] irq_mask_ff;
    logic [15:0] rdata_ff;
    logic [5:0] div_cnt_ff;
    logic tick_ff;
    asc_state_t state_ff;
    asc_state_t nxt_state;
    logic [2:0] phase_cnt_ff;
    logic [1:0] chan_ff;
    logic [SLOT_W-1:0] slot_ff;
    logic [2:0] done_cnt_ff;

    logic enabled;
    logic ctrl_wr;
    logic ctrl_off;
    logic [15:0] ctrl_new;
    logic start;
    logic phase_end;
    logic conv_done;
    logic seq_last;
    logic flag_set;
    logic [1:0] res_idx;
    asc_mode_t mode;

    assign enabled = ctrl_ff[ASC_ENABLE_BIT];
    assign mode = asc_mode_t'(ctrl_ff[ASC_MODE_LSB +: 2]);
    assign ctrl_wr = reg_wr && reg_addr == ASC_CTRL_IDX;

    // A write that clears the enable stops the sequencer at once, so the
    // core never runs a cycle after software has switched it off
    assign ctrl_off = ctrl_wr && !ctrl_new[ASC_ENABLE_BIT];

    // Disabled, only the enable bit takes a write
    always_comb begin
        ctrl_new = ctrl_ff;
        if (enabled) begin
            ctrl_new = reg_wdata & ASC_CTRL_WMASK;
        end else begin
            ctrl_new[ASC_ENABLE_BIT] = reg_wdata[ASC_ENABLE_BIT];
        end
    end

    // Control word store
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_ff <= ASC_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_ff <= ctrl_new;
        end
    end

    // Start trigger select; a write start uses the freshly written word
    always_comb begin
        start = 1'b0;
        if (ctrl_wr) begin
            start = ctrl_new[ASC_ENABLE_BIT] && enabled
                && ctrl_new[ASC_SRC_LSB +: 2] == ASC_SRC_WRITE;
        end
        if (enabled) begin
            case (asc_src_t'(ctrl_ff[ASC_SRC_LSB +: 2]))
                ASC_SRC_EXT1: start = start || external_irq_one;
                ASC_SRC_GT2: start = start || general_timer_two;
                ASC_SRC_T0: start = start || timer_zero;
                default: start = start;
            endcase
        end
    end

    // Converter clock divider, restarted with each start and held in idle so that
    // every phase gets whole periods
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_ff <= 6'h0;
            tick_ff <= 1'b0;
        end else if (start || state_ff == ASC_IDLE) begin
            div_cnt_ff <= 6'h0;
            tick_ff <= 1'b0;
        end else if (div_cnt_ff >= div_last(ctrl_ff[ASC_DIV_LSB +: 3])) begin
            div_cnt_ff <= 6'h0;
            tick_ff <= 1'b1;
        end else begin
            div_cnt_ff <= div_cnt_ff + 6'h1;
            tick_ff <= 1'b0;
        end
    end

    // Phase length reached on this converter clock
    always_comb begin
        phase_end = 1'b0;
        case (state_ff)
            ASC_AZERO: phase_end = phase_cnt_ff == ASC_AZ_TICKS - 3'h1;
            ASC_SAMPLE: phase_end = phase_cnt_ff == ASC_SAMPLE_TICKS - 3'h1;
            ASC_CONVERT: phase_end = phase_cnt_ff == ASC_CONV_TICKS - 3'h1;
            default: phase_end = 1'b0;
        endcase
        phase_end = phase_end && tick_ff;
    end

    assign conv_done = state_ff == ASC_CONVERT && phase_end && !start;

    // Last conversion of a stopping sequence
    always_comb begin
        case (mode)
            ASC_MODE_SINGLE: seq_last = 1'b1;
            ASC_MODE_LOOP: seq_last = 1'b0;
            default: seq_last = slot_ff == SLOT_W'(NUM_CH - 1);
        endcase
    end

    // Phase sequencer: auto-zero, sample, convert, then next or idle
    always_comb begin
        nxt_state = state_ff;
        if (!enabled || ctrl_off) begin
            nxt_state = ASC_IDLE;
        end else if (start) begin
            nxt_state = ASC_AZERO;
        end else if (phase_end) begin
            case (state_ff)
                ASC_AZERO: nxt_state = ASC_SAMPLE;
                ASC_SAMPLE: nxt_state = ASC_CONVERT;
                ASC_CONVERT: nxt_state = seq_last ? ASC_IDLE : ASC_AZERO;
                default: nxt_state = ASC_IDLE;
            endcase
        end
    end

    // State and phase tick count
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= ASC_IDLE;
            phase_cnt_ff <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            if (start || phase_end || !enabled) begin
                phase_cnt_ff <= 3'h0;
            end else if (tick_ff) begin
                phase_cnt_ff <= phase_cnt_ff + 3'h1;
            end
        end
    end

    // Channel and slot stepping; quad mode keeps the channel fixed
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chan_ff <= 2'h0;
            slot_ff <= '0;
        end else if (start) begin
            chan_ff <= ctrl_wr ? ctrl_new[ASC_CHAN_LSB +: 2]
                : ctrl_ff[ASC_CHAN_LSB +: 2];
            slot_ff <= '0;
        end else if (conv_done) begin
            slot_ff <= slot_ff + SLOT_W'(1);
            if (mode == ASC_MODE_SCAN || mode == ASC_MODE_LOOP) begin
                chan_ff <= next_ch(chan_ff);
            end
        end
    end

    // Quad mode writes by slot, other modes by channel
    assign res_idx = mode == ASC_MODE_QUAD ? 2'(slot_ff)
        : chan_ff;

    // Result capture from the analog core
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                result_ff[i] <= '0;
            end
        end else if (conv_done) begin
            result_ff[res_idx] <= core_result;
        end
    end

    // Completions since start, saturating at seven
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            done_cnt_ff <= 3'h0;
        end else if (start) begin
            done_cnt_ff <= 3'h0;
        end else if (conv_done && done_cnt_ff != 3'h7) begin
            done_cnt_ff <= done_cnt_ff + 3'h1;
        end
    end

    // Flag sets on the first or fourth completion when enabled
    assign flag_set = conv_done && ctrl_ff[ASC_IRQEN_BIT]
        && done_cnt_ff == (ctrl_ff[ASC_AFTER4_BIT] ? 3'h3 : 3'h0);

    // Control write clears the flag; a same-cycle set still wins
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_ff <= 1'b0;
        end else if (flag_set) begin
            flag_ff <= 1'b1;
        end else if (ctrl_wr) begin
            flag_ff <= 1'b0;
        end
    end

    // Sticky event status, write one to clear, set wins
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_stat_ff <= ASC_IRQ_RST;
        end else begin
            for (int b = 0; b < 3; b++) begin
                if (reg_wr && enabled && reg_addr == ASC_IRQ_STAT_IDX
                    && reg_wdata[b]) begin
                    irq_stat_ff[b] <= 1'b0;
                end
            end
            if (flag_set) begin
                irq_stat_ff[ASC_EV_FLAG] <= 1'b1;
            end
            if (conv_done) begin
                irq_stat_ff[ASC_EV_RESULT] <= 1'b1;
            end
            if (conv_done && seq_last) begin
                irq_stat_ff[ASC_EV_SEQDONE] <= 1'b1;
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_mask_ff <= ASC_IRQ_RST;
        end else if (reg_wr && enabled && reg_addr == ASC_IRQ_MASK_IDX) begin
            irq_mask_ff <= reg_wdata[2:0];
        end
    end

    // Read data one cycle after the strobe; blocked reads return zero
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= 16'h0000;
        end else if (reg_rd && enabled) begin
            case (reg_addr)
                ASC_CTRL_IDX: begin
                    rdata_ff <= ctrl_ff;
                    rdata_ff[ASC_FLAG_BIT] <= flag_ff;
                end
                ASC_IRQ_STAT_IDX: rdata_ff <= {13'h0, irq_stat_ff};
                ASC_IRQ_MASK_IDX: rdata_ff <= {13'h0, irq_mask_ff};
                default: begin
                    if (reg_addr >= ASC_RES0_IDX
                        && reg_addr < ASC_RES0_IDX + 3'(NUM_CH)) begin
                        rdata_ff <= 16'(result_ff[2'(reg_addr
                            - ASC_RES0_IDX)]);
                    end else begin
                        rdata_ff <= 16'h0000;
                    end
                end
            endcase
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_ff;

    // Analog core controls; phase levels decoded from the phase register, channel and clock enable taken from their registers
    assign core_channel = chan_ff;
    assign core_autozero = state_ff == ASC_AZERO;
    assign core_sample = state_ff == ASC_SAMPLE;
    assign core_convert = state_ff == ASC_CONVERT;
    assign core_clk_en = tick_ff;

    // Level interrupt while any unmasked event is pending
    assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule : asc_sequence_control
`default_nettype wire

//--- dv/asc_sva.sv
// Port-level checker for the converter sequence control block
`default_nettype none
module asc_sva
    import asc_pkg::*;
(
    // Clock, reset and register port
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Start triggers
    input wire logic external_irq_one,
    input wire logic general_timer_two,
    input wire logic timer_zero,
    // Analog core side
    input wire logic core_autozero,
    input wire logic core_sample,
    input wire logic core_convert,
    input wire logic core_clk_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic en_ff;
    logic [1:0] src_ff;
    logic wr_ctl;
    logic trig;
    logic busy;
    assign wr_ctl = reg_wr && reg_addr == ASC_CTRL_IDX;
    assign busy = core_autozero || core_sample || core_convert;
    assign trig = |({timer_zero, general_timer_two, external_irq_one, 1'b0}
        & (4'h1 << src_ff));
    // Mirror of enable and source; the enable bit is writable at any time
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_ff <= 1'b0;
            src_ff <= 2'h0;
        end else if (wr_ctl) begin
            en_ff <= reg_wdata[ASC_ENABLE_BIT];
            src_ff <= en_ff ? reg_wdata[9:8] : src_ff;
        end
    end
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
    property p_off; reg_rd && !en_ff |=> reg_rdata == 16'h0000; endproperty
    property p_wr_start;
        wr_ctl && en_ff && reg_wdata[15] && reg_wdata[9:8] == 2'h0
            |=> core_autozero;
    endproperty
    property p_trig; en_ff && !wr_ctl && trig |=> core_autozero; endproperty
    property p_stop; wr_ctl && !reg_wdata[15] |=> !busy [*2]; endproperty
    property p_az; $rose(core_sample) |-> $past(core_autozero); endproperty
    property p_conv; $rose(core_convert) |-> $past(core_sample); endproperty
    property p_tick; core_clk_en |=> !core_clk_en [*7]; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray rdata");
    a_off: assert property (p_off) else $error("read while off");
    a_wr_start: assert property (p_wr_start) else $error("no start");
    a_trig: assert property (p_trig) else $error("no restart");
    a_stop: assert property (p_stop) else $error("runs while off");
    a_az: assert property (p_az) else $error("sample w/o zero");
    a_conv: assert property (p_conv) else $error("bad phase");
    a_tick: assert property (p_tick) else $error("tick too fast");
    c_trig: cover property (en_ff && trig);
    c_conv: cover property ($rose(core_convert));
    c_stop: cover property (wr_ctl && !reg_wdata[15] && busy);
endmodule : asc_sva
bind asc_sequence_control asc_sva u_sva (
    .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .external_irq_one, .general_timer_two, .timer_zero,
    .core_autozero, .core_sample, .core_convert, .core_clk_en
);
`default_nettype wire

//--- dv/asc_core_model.sv
// Behavioural analog core: tags each sample with channel and count
`default_nettype none
module asc_core_model (
    input wire logic core_clk,
    input wire logic [1:0] core_channel,
    input wire logic core_sample,
    input wire logic core_convert,
    output logic [7:0] core_result
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] seq_ff = 6'h00;
    logic [7:0] held_ff = 8'h00;
    logic samp_ff = 1'b0;
    // One 8-bit value per sampling period of the selected input
    always_ff @(posedge core_clk) begin
        samp_ff <= core_sample;
        if (core_sample && !samp_ff) begin
            seq_ff <= seq_ff + 6'h01;
            held_ff <= {core_channel, seq_ff + 6'h01};
        end
    end
    // Outside conversion the output is not valid, so show the inverse
    assign core_result = core_convert ? held_ff : ~held_ff;
endmodule : asc_core_model
`default_nettype wire

//--- dv/adc_sequence_control_bench.sv
// Self-checking bench for the converter sequence control block
`default_nettype none
module adc_sequence_control_bench
    import asc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, sys_rst, reg_wr, reg_rd, irq, core_clk_en;
    logic external_irq_one, general_timer_two, timer_zero;
    logic core_autozero, core_sample, core_convert;
    logic rd_d = 1'b0;
    logic [2:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, c;
    logic [7:0] core_result, ex [4];
    logic [1:0] ch, s;
    logic [15:0] exp_q [$];
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int nconv = 0;

    asc_sequence_control uut (
        .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .external_irq_one, .general_timer_two, .timer_zero,
        .core_result, .core_channel(ch), .core_autozero, .core_sample,
        .core_convert, .core_clk_en, .irq
    );
    asc_core_model u_core (
        .core_clk, .core_channel(ch), .core_sample, .core_convert,
        .core_result
    );

    task automatic results();
        $display("compared %0d, failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    task automatic bad(input logic [15:0] got, input logic [15:0] e);
        n_compared++;
        if (got !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, e);
        end
    endtask : bad
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
    endtask : rd
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask : idle
    // Write the control word, then pulse the selected trigger if any
    task automatic go(input logic [15:0] w);
        wr(ASC_CTRL_IDX, w);
        idle(3);
        if (w[9:8] != 2'h0) begin
            {timer_zero, general_timer_two, external_irq_one} <=
                3'h1 << (w[9:8] - 2'h1);
            @(posedge core_clk);
            {timer_zero, general_timer_two, external_irq_one} <= 3'h0;
        end
    endtask : go
    // Wait for one result event, then clear status by writing ones
    task automatic wait_irq();
        idle(1);
        for (int k = 0; k < 4000 && irq !== 1'b1; k++) @(negedge core_clk);
        bad({15'h0, irq}, 16'h0001);
        @(posedge core_clk);
        wr(ASC_IRQ_STAT_IDX, 16'h0007);
        nconv++;
    endtask : wait_irq

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Read data are valid only in the cycle after the strobe
    always @(posedge core_clk) rd_d <= reg_rd;
    always @(negedge core_clk) if (rd_d === 1'b1) bad(reg_rdata,
        exp_q.pop_front());
    // Worst case is about 20 conversions at the slowest divider
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        void'($urandom(32'h1A9A0E59));
        {reg_wr, reg_rd, external_irq_one, general_timer_two} = 4'h0;
        timer_zero = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 16'h0000;
        sys_rst = 1'b1;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        // Disabled: only the enable bit accepts a write
        wr(ASC_IRQ_MASK_IDX, 16'h0002);
        rd(ASC_IRQ_MASK_IDX, 16'h0000);
        wr(ASC_CTRL_IDX, 16'hFFFF);
        rd(ASC_CTRL_IDX, 16'h8000);
        wr(ASC_CTRL_IDX, 16'hFFFF);
        rd(ASC_CTRL_IDX, 16'h8FFF);
        wr(3'h7, 16'hFFFF);
        rd(3'h7, 16'h0000);
        wr(ASC_IRQ_MASK_IDX, 16'h0002);
        rd(ASC_IRQ_MASK_IDX, 16'h0002);
        // Single conversions: every input, source and a random divider
        for (int i = 0; i < 4; i++) begin
            s = i[1:0];
            c = {5'h10, i[0], s, 3'($urandom % 8), 3'h2, s};
            go(c);
            wait_irq();
            rd(ASC_RES0_IDX + 3'(s), {8'h00, s, 6'(nconv)});
            rd(ASC_CTRL_IDX, c | {3'h0, i[0], 12'h000});
        end
        // Four-times mode on input two, then scan from input three
        for (int m = 0; m < 2; m++) begin
            s = m ? 2'h3 : 2'h2;
            c = {6'h23, 2'h0, 3'($urandom % 8), m[0], 2'h0, s};
            go(c);
            for (int k = 0; k < 4; k++) begin
                wait_irq();
                ex[k] = {m ? s + 2'(k) : s, 6'(nconv)};
                if (k == 0) rd(ASC_CTRL_IDX, c);
            end
            rd(ASC_CTRL_IDX, c | 16'h1000);
            for (int k = 0; k < 4; k++) begin
                ch = m ? s + 2'(k) : 2'(k);
                rd(ASC_RES0_IDX + 3'(ch), {8'h00, ex[k]});
            end
        end
        // A second start during auto-zero replaces the first
        wr(ASC_CTRL_IDX, 16'h8409);
        go(16'h8408);
        wait_irq();
        rd(ASC_RES0_IDX, {10'h000, 6'(nconv)});
        idle(700);
        rd(ASC_IRQ_STAT_IDX, 16'h0000);
        // Continuous scan from input one, then masked and stopped
        go(16'h8419);
        for (int k = 0; k < 5; k++) begin
            wait_irq();
            s = 2'h1 + 2'(k);
            rd(ASC_RES0_IDX + 3'(s), {8'h00, s, 6'(nconv)});
        end
        wr(ASC_IRQ_MASK_IDX, 16'h0000);
        idle(200);
        bad({15'h0, irq}, 16'h0000);
        wr(ASC_CTRL_IDX, 16'h0000);
        rd(ASC_CTRL_IDX, 16'h0000);
        idle(3);
        results();
    end
endmodule : adc_sequence_control_bench
`default_nettype wire
